// ===== ipf_top.sv
// Priority field registers with AXI4-Lite access and per-source request gating
// What this block does
// RQ1 - Field value is level, 7 highest, 1 lowest
// RQ2 - Zero field disables its source
// RQ3 - Unimplemented bits read zero, ignore writes
// RQ4 - Fields reset to level 4, read/write
// RQ5 - Timer4 field at bits 14 to 12
// RQ6 - Compare channel 4 field bits 10 to 8
// RQ7 - Compare channel 3 field bits 6 to 4
// RQ8 - Present fields; zero-level sources never forwarded
`timescale 1ns/1ps
module ipf_top
  import ipf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ipf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ipf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-source flags and enables, same clock domain
  input wire logic [ipf_pkg::NUM_SRC-1:0] src_flag,
  input wire logic [ipf_pkg::NUM_SRC-1:0] src_enable,
  // Priority levels to the arbiter
  output logic [ipf_pkg::PRIO_W-1:0] capture_ch8_priority,
  output logic [ipf_pkg::PRIO_W-1:0] capture_ch7_priority,
  output logic [ipf_pkg::PRIO_W-1:0] ext_irq1_priority,
  output logic [ipf_pkg::PRIO_W-1:0] timer4_priority,
  output logic [ipf_pkg::PRIO_W-1:0] compare_ch4_priority,
  output logic [ipf_pkg::PRIO_W-1:0] compare_ch3_priority,
  // Forwarded pending requests
  output logic [ipf_pkg::NUM_SRC-1:0] src_req
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] capture_and_external_priority; // Holds ch8, ch7 and ext irq1 fields
  logic [15:0] timer_and_compare_priority; // Holds timer4, ch4 and ch3 fields
  // Write channel captures, either order
  logic aw_held; // Write address latched
  logic w_held; // Write data latched
  logic [ADDR_W-1:0] aw_addr; // Latched write address
  logic [31:0] w_data; // Latched write data
  logic [3:0] w_strb; // Latched byte strobes
  // ----------------------------------------
  // Write path decode
  // ----------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
  wire have_aw = aw_take | aw_held;
  wire have_w = w_take | w_held;
  wire do_write = have_aw & have_w & ~s_axi_bvalid;
  wire hit_cap = (wr_addr == CAP_EXT_OFFSET);
  wire hit_tmr = (wr_addr == TMR_CMP_OFFSET);
  wire wr_mapped = hit_cap | hit_tmr;
  // Byte strobes widened to a 16-bit lane mask
  wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  // Only implemented bits take the write
  wire [15:0] cap_wmask = lane_mask & CAP_EXT_MASK; // RQ3
  wire [15:0] tmr_wmask = lane_mask & TMR_CMP_MASK; // RQ3
  wire [15:0] next_cap = (capture_and_external_priority & ~cap_wmask)
                       | (wr_data[15:0] & cap_wmask);
  wire [15:0] next_tmr = (timer_and_compare_priority & ~tmr_wmask)
                       | (wr_data[15:0] & tmr_wmask);
  // ----------------------------------------
  // Priority registers
  // ----------------------------------------
  // Fields load level 4 at reset, software may rewrite them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_and_external_priority <= CAP_EXT_RESET; // RQ4
      timer_and_compare_priority <= TMR_CMP_RESET; // RQ4
    end else if (do_write && hit_cap) begin
      capture_and_external_priority <= next_cap;
    end else if (do_write && hit_tmr) begin
      timer_and_compare_priority <= next_tmr;
    end
  end
  // ----------------------------------------
  // Write handshake
  // ----------------------------------------
  // Hold each channel until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= have_aw & ~do_write;
      w_held <= have_w & ~do_write;
    end
  end
  // Ready while nothing of that channel is held and no response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~(have_aw & ~do_write) & ~(do_write | s_axi_bvalid);
      s_axi_wready <= ~(have_w & ~do_write) & ~(do_write | s_axi_bvalid);
    end
  end
  // Response follows the write by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  // Unimplemented positions forced to zero on read
  wire [31:0] rd_cap = {16'h0000, capture_and_external_priority & CAP_EXT_MASK}; // RQ3
  wire [31:0] rd_tmr = {16'h0000, timer_and_compare_priority & TMR_CMP_MASK}; // RQ3
  wire [31:0] rd_stat = {26'h000_0000, src_req};
  wire rd_hit_cap = (s_axi_araddr == CAP_EXT_OFFSET);
  wire rd_hit_tmr = (s_axi_araddr == TMR_CMP_OFFSET);
  wire rd_hit_stat = (s_axi_araddr == SRC_STAT_OFFSET);
  wire [31:0] rd_mux = rd_hit_cap ? rd_cap
                     : rd_hit_tmr ? rd_tmr
                     : rd_hit_stat ? rd_stat
                     : 32'h0000_0000;
  wire rd_ok = rd_hit_cap | rd_hit_tmr | rd_hit_stat;
  // Read address taken only when no data is waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~ar_take & ~s_axi_rvalid;
    end
  end
  // Data answered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  // Fields as levels: 7 ranks highest, 1 lowest, 0 disabled
  wire [PRIO_W-1:0] f_ext = capture_and_external_priority[EXT_IRQ1_LSB +: PRIO_W]; // RQ1
  wire [PRIO_W-1:0] f_ch7 = capture_and_external_priority[CAP_CH7_LSB +: PRIO_W];
  wire [PRIO_W-1:0] f_ch8 = capture_and_external_priority[CAP_CH8_LSB +: PRIO_W];
  wire [PRIO_W-1:0] f_c3 = timer_and_compare_priority[CMP_CH3_LSB +: PRIO_W]; // RQ7
  wire [PRIO_W-1:0] f_c4 = timer_and_compare_priority[CMP_CH4_LSB +: PRIO_W]; // RQ6
  wire [PRIO_W-1:0] f_t4 = timer_and_compare_priority[TIMER4_LSB +: PRIO_W]; // RQ5
  // Levels indexed in source order for the gates
  wire [PRIO_W-1:0] prio_vec [NUM_SRC];
  assign prio_vec[SRC_EXT_IRQ1] = f_ext;
  assign prio_vec[SRC_CAP_CH7] = f_ch7;
  assign prio_vec[SRC_CAP_CH8] = f_ch8;
  assign prio_vec[SRC_CMP_CH3] = f_c3;
  assign prio_vec[SRC_CMP_CH4] = f_c4;
  assign prio_vec[SRC_TIMER4] = f_t4;
  // Levels registered for the arbiter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_ch8_priority <= PRIO_RESET;
      capture_ch7_priority <= PRIO_RESET;
      ext_irq1_priority <= PRIO_RESET;
      timer4_priority <= PRIO_RESET;
      compare_ch4_priority <= PRIO_RESET;
      compare_ch3_priority <= PRIO_RESET;
    end else begin
      capture_ch8_priority <= f_ch8; // RQ8
      capture_ch7_priority <= f_ch7;
      ext_irq1_priority <= f_ext;
      timer4_priority <= f_t4;
      compare_ch4_priority <= f_c4;
      compare_ch3_priority <= f_c3;
    end
  end
  // ----------------------------------------
  // Request gating
  // ----------------------------------------
  // One gate per source, each with its own registered request
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    ipf_src_gate u_gate (
      .aclk(aclk),
      .aresetn(aresetn),
      .prio(prio_vec[i]),
      .flag(src_flag[i]),
      .enable(src_enable[i]),
      .req(src_req[i])
    );
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Unimplemented bits of the first register read back as zero
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    ar_take && rd_hit_cap |=> (s_axi_rdata & ~{16'h0000, CAP_EXT_MASK}) == 32'h0000_0000)
    else $error("unimplemented bit read as one");
  // Unimplemented bits of the second register read back as zero
  a_unimpl_tmr: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    ar_take && rd_hit_tmr |=> (s_axi_rdata & ~{16'h0000, TMR_CMP_MASK}) == 32'h0000_0000)
    else $error("unimplemented bit of second register read as one");
  // Unmapped read answers zero with an error response
  a_rresp_err: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    ar_take && !rd_ok |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // Unmapped write changes no field
  a_unmapped_keep: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    do_write && !wr_mapped |=> $stable(capture_and_external_priority)
      && $stable(timer_and_compare_priority))
    else $error("unmapped write changed a field");
  // Unmapped write answered with an error response
  a_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
    do_write && !wr_mapped |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  // Timer4 and ext irq1 level outputs right after reset
  a_reset_level: assert property (@(posedge aclk) // RQ4
    $rose(aresetn) |-> timer4_priority == PRIO_RESET && ext_irq1_priority == PRIO_RESET)
    else $error("field not level 4 after reset");
  // Both registers hold their defaults right after reset
  a_reset_regs: assert property (@(posedge aclk) // RQ4
    $rose(aresetn) |-> capture_and_external_priority == CAP_EXT_RESET
      && timer_and_compare_priority == TMR_CMP_RESET)
    else $error("register not at default after reset");
  // No request stands right after reset
  a_no_req_rst: assert property (@(posedge aclk) // RQ8
    $rose(aresetn) |-> src_req == '0)
    else $error("request pending after reset");
  // Timer4 level taken from its own field
  a_timer4_pos: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    ##1 timer4_priority == $past(timer_and_compare_priority[14:12]))
    else $error("timer4 field misplaced");
  // Compare ch4 level taken from its own field
  a_cmp4_pos: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
    ##1 compare_ch4_priority == $past(timer_and_compare_priority[10:8]))
    else $error("compare ch4 field misplaced");
  // Compare ch3 level taken from its own field
  a_cmp3_pos: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
    ##1 compare_ch3_priority == $past(timer_and_compare_priority[6:4]))
    else $error("compare ch3 field misplaced");
  // Capture ch8 level taken from its own field
  a_ch8_pos: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    ##1 capture_ch8_priority == $past(capture_and_external_priority[14:12]))
    else $error("capture ch8 field misplaced");
  // Capture ch7 level taken from its own field
  a_ch7_pos: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    ##1 capture_ch7_priority == $past(capture_and_external_priority[10:8]))
    else $error("capture ch7 field misplaced");
  // External irq1 level taken from its own field
  a_ext_pos: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    ##1 ext_irq1_priority == $past(capture_and_external_priority[2:0]))
    else $error("ext irq1 field misplaced");
  // A written level reaches the arbiter two cycles later
  a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
    do_write && hit_tmr && wr_strb[1] |=> ##1 timer4_priority == $past(wr_data[14:12], 2))
    else $error("written level not presented");
  // Every write is answered on the next cycle
  a_bresp_order: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
  // Read data follows an accepted address by one cycle
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rvalid)
    else $error("read response missing");
  // Both write channels refused while a response waits
  a_busy_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  // Disabled timer4 never forwarded
  a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    $past(f_t4) == PRIO_OFF |-> !src_req[SRC_TIMER4])
    else $error("disabled timer4 forwarded");
endmodule

// ===== ipf_pkg.sv
// Package of register map, field layout and reset values for the priority fields
package ipf_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] CAP_EXT_OFFSET = 4'h0; // capture_and_external_priority
  localparam logic [3:0] TMR_CMP_OFFSET = 4'h4; // timer_and_compare_priority
  localparam logic [3:0] SRC_STAT_OFFSET = 4'h8; // read-only forwarded request view
  localparam int ADDR_W = 4;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PRIO_W = 3;
  localparam int NUM_SRC = 6;
  localparam int EXT_IRQ1_LSB = 0;
  localparam int CAP_CH7_LSB = 8;
  localparam int CAP_CH8_LSB = 12;
  localparam int CMP_CH3_LSB = 4;
  localparam int CMP_CH4_LSB = 8;
  localparam int TIMER4_LSB = 12;
  // Writable bit masks; every other bit is unimplemented
  localparam logic [15:0] CAP_EXT_MASK = 16'h7707;
  localparam logic [15:0] TMR_CMP_MASK = 16'h7770;
  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [15:0] CAP_EXT_RESET = 16'h4404;
  localparam logic [15:0] TMR_CMP_RESET = 16'h4440;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Source order on the request vectors
  typedef enum logic [2:0] {
    SRC_EXT_IRQ1,
    SRC_CAP_CH7,
    SRC_CAP_CH8,
    SRC_CMP_CH3,
    SRC_CMP_CH4,
    SRC_TIMER4
  } ipf_src_t;
endpackage

// ===== ipf_src_gate.sv
// Per-source gate that forwards a request only when its priority is non-zero
`timescale 1ns/1ps
module ipf_src_gate
  import ipf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ipf_pkg::PRIO_W-1:0] prio,
  input wire logic flag,
  input wire logic enable,
  output logic req
);
  // ----------------------------------------
  // Gate
  // ----------------------------------------
  // Zero level means the source is disabled
  wire live = (prio != PRIO_OFF); // RQ2
  wire next_req = flag & enable & live;
  // Registered so the top output comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req <= 1'b0;
    end else begin
      req <= next_req; // RQ8
    end
  end
  // Disabled source never forwarded
  a_off_no_req: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
    $past(prio) == PRIO_OFF |-> !req)
    else $error("request forwarded from disabled source");
  // Live source forwarded one cycle after flag and enable
  a_live_req: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
    (flag && enable && prio != PRIO_OFF) |=> req)
    else $error("live request not forwarded");
endmodule

// ===== ipf_top_bench.sv
// Self-checking bench for the priority field registers and request gating
`timescale 1ns/1ps
module ipf_top_bench;
  import ipf_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] src_flag, src_enable, src_req;
  logic [2:0] p_ch8, p_ch7, p_ext, p_tmr, p_cmp4, p_cmp3;
  logic [33:0] bq[$]; // Expected write responses
  logic [33:0] rq[$]; // Expected read response and data
  logic [15:0] m0, m1; // Register model
  logic [31:0] d;
  logic [3:0] a, s;
  int n_errors = 0;
  int comparisons = 0;
  // Clock at 200 MHz
  always #2.5 aclk = ~aclk;
  ipf_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_flag(src_flag), .src_enable(src_enable),
    .capture_ch8_priority(p_ch8), .capture_ch7_priority(p_ch7), .ext_irq1_priority(p_ext),
    .timer4_priority(p_tmr), .compare_ch4_priority(p_cmp4), .compare_ch3_priority(p_cmp3),
    .src_req(src_req));
  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Monitor takes the oldest note whenever a response is accepted
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      if (bq.size() == 0) n_errors++;
      else check({s_axi_bresp, 32'h0000_0000}, bq.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      if (rq.size() == 0) n_errors++;
      else check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
  end
  // Watchdog against a hung handshake
  initial begin
    #50us;
    n_errors++;
    conclude();
  end
  // ----------------------------------------
  // Bus tasks and model
  // ----------------------------------------
  // Write: hold each channel until taken, bready until bvalid seen
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt, input logic [3:0] st);
    bq.push_back({(ad > 4'h4) ? 2'h2 : 2'h0, 32'h0000_0000});
    if (ad == 4'h0) m0 = ((dt[15:0] & {{8{st[1]}}, {8{st[0]}}}) |
      (m0 & ~{{8{st[1]}}, {8{st[0]}}})) & 16'h7707;
    if (ad == 4'h4) m1 = ((dt[15:0] & {{8{st[1]}}, {8{st[0]}}}) |
      (m1 & ~{{8{st[1]}}, {8{st[0]}}})) & 16'h7770;
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dt;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Read: expectation is noted before the address is offered
  task automatic rd(input logic [3:0] ad, input logic [33:0] exp);
    rq.push_back(exp);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Requests expected from the model fields and the driven levels
  function automatic logic [5:0] exp_req();
    logic [5:0] nz;
    nz = {|m1[14:12], |m1[10:8], |m1[6:4], |m0[14:12], |m0[10:8], |m0[2:0]};
    return nz & src_flag & src_enable;
  endfunction
  // Level outputs against the model after things settle
  task automatic check_outs();
    repeat (3) @(posedge aclk);
    check({31'h0, p_ch8}, {31'h0, m0[14:12]});
    check({31'h0, p_ch7}, {31'h0, m0[10:8]});
    check({31'h0, p_ext}, {31'h0, m0[2:0]});
    check({31'h0, p_tmr}, {31'h0, m1[14:12]});
    check({31'h0, p_cmp4}, {31'h0, m1[10:8]});
    check({31'h0, p_cmp3}, {31'h0, m1[6:4]});
    check({28'h0, src_req}, {28'h0, exp_req()});
    rd(4'h8, {28'h0, exp_req()});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h6a20f438));
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    src_flag = 6'h3f;
    src_enable = 6'h3f;
    m0 = 16'h4404;
    m1 = 16'h4440;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values, then every implemented bit set
    check_outs();
    rd(4'h0, {18'h0, 16'h4404});
    rd(4'h4, {18'h0, 16'h4440});
    wr(4'h0, 32'hffff_ffff, 4'hf);
    wr(4'h4, 32'hffff_ffff, 4'hf);
    rd(4'h0, {18'h0, 16'h7707});
    rd(4'h4, {18'h0, 16'h7770});
    check_outs();
    // Unmapped place refuses both ways
    wr(4'hc, 32'hffff_ffff, 4'hf);
    rd(4'hc, {2'h2, 32'h0000_0000});
    // All fields off while every source is flagged and enabled
    wr(4'h0, 32'h0000_0000, 4'h3);
    wr(4'h4, 32'h0000_0000, 4'h3);
    check_outs();
    // Random fields, strobes and request levels
    repeat (40) begin
      a = 4'($urandom_range(0, 1) * 4);
      d = $urandom & $urandom;
      s = 4'($urandom_range(0, 15));
      wr(a, d, s);
      src_flag <= 6'($urandom);
      src_enable <= 6'($urandom);
      check_outs();
      rd(a, {18'h0, (a == 4'h0) ? m0 : m1});
    end
    // Second reset in mid-run restores the defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m0 = 16'h4404;
    m1 = 16'h4440;
    repeat (2) @(posedge aclk);
    check_outs();
    rd(4'h4, {18'h0, 16'h4440});
    repeat (2) @(posedge aclk);
    conclude();
  end
endmodule
